// *** hw/dlt_pkg.sv ***
package dlt_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the apb window
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CLK = 8'h08;
  localparam logic [7:0] ADDR_A_LOW = 8'h0c;
  localparam logic [7:0] ADDR_A_HIGH = 8'h10;
  localparam logic [7:0] ADDR_B_LOW = 8'h14;
  localparam logic [7:0] ADDR_B_HIGH = 8'h18;
  localparam logic [7:0] ADDR_EXTCFG = 8'h1c;
  localparam logic [7:0] ADDR_INTEN = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_B_FLAG = 7;
  localparam int CTRL_B_RUN = 6;
  localparam int CTRL_A_FLAG = 5;
  localparam int CTRL_A_RUN = 4;
  localparam int MODE_B_GATE = 7;
  localparam int MODE_B_CT = 6;
  localparam int MODE_B_LSB = 4;
  localparam int MODE_A_GATE = 3;
  localparam int MODE_A_CT = 2;
  localparam int MODE_A_LSB = 0;
  localparam int CLK_B_SYS = 3;
  localparam int CLK_A_SYS = 2;
  localparam int CLK_PRESC_LSB = 0;
  localparam int EXTCFG_A_POL = 0;
  localparam int EXTCFG_B_POL = 1;
  localparam int INTEN_A = 0;
  localparam int INTEN_B = 1;

  // synchroniser lanes
  localparam int PIN_EV_A = 0;
  localparam int PIN_EV_B = 1;
  localparam int PIN_GATE_A = 2;
  localparam int PIN_GATE_B = 3;
  localparam int PIN_EXT = 4;
  localparam int PIN_N = 5;

  // ----------------------------------------------------------------
  // reset values, encodings and divisors
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] MODE_13 = 2'b00;
  localparam logic [1:0] MODE_16 = 2'b01;
  localparam logic [1:0] MODE_RELOAD = 2'b10;
  localparam logic [1:0] MODE_SPLIT = 2'b11;
  localparam logic [1:0] PRESC_DIV12 = 2'b00;
  localparam logic [1:0] PRESC_DIV4 = 2'b01;
  localparam logic [1:0] PRESC_DIV48 = 2'b10;
  localparam logic [1:0] PRESC_EXT8 = 2'b11;
  localparam logic [5:0] DIV_12 = 6'h0c;
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_48 = 6'h30;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dlt_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dlt_apb_rsp_s;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
  } dlt_step_s;

endpackage : dlt_pkg

// *** hw/dlt_timers.sv ***
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - count event pin falling edges
// - count events up to quarter clock
// - 16-bit count as low/high bytes
// - 13-bit: high byte plus low five
// - 13-bit wrap sets flag, interrupt
// - select event, system or prescaled clock
// - outside split, advance only when run and gate
// - run bit never reloads count
// - timer b has own controls, polarity
// - 16-bit mode uses all bits
// - 8-bit reload from high byte
// - split: low byte uses a controls
// - split: high byte uses b run, flag
// - split: timer b flagless, runs by mode
// - timer b overflow always drives pulse
// - mode 3 stops timer b
// - interrupt only when enabled
// - timers configured independently
// - two-bit mode field encoding
// - prescale: /12, /4, /48, ext/8
// - flags cleared by software or vectoring
module dlt_timers
  import dlt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input wire dlt_apb_req_s apb_req,
  output dlt_apb_rsp_s apb_rsp,
  // pins, asynchronous to clk
  input wire logic timer_a_event_pin,
  input wire logic timer_b_event_pin,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic ext_clk_pin,
  // processor vectoring acknowledge
  input wire logic isr_ack_a,
  input wire logic isr_ack_b,
  // interrupt and overflow outputs
  output logic irq_timer_a,
  output logic irq_timer_b,
  output logic timer_b_overflow_pulse
);

  // ----------------------------------------------------------------
  // count step shared by both timers
  // ----------------------------------------------------------------
  function automatic dlt_step_s dlt_step(input logic [1:0] mode, input logic [7:0] lo,
                                         input logic [7:0] hi);
    dlt_step_s r;
    logic [12:0] c13;
    logic [15:0] c16;
    r.low = lo;
    r.high = hi;
    r.ovf = 1'b0;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    unique case (mode)
      MODE_13: begin
        r.high = c13[12:5];
        r.low = {lo[7:5], c13[4:0]};
        r.ovf = ({hi, lo[4:0]} == 13'h1fff);
      end
      MODE_16: begin
        r.high = c16[15:8];
        r.low = c16[7:0];
        r.ovf = ({hi, lo} == 16'hffff);
      end
      MODE_RELOAD: begin
        r.low = (lo == 8'hff) ? hi : lo + 8'h01;
        r.ovf = (lo == 8'hff);
      end
      MODE_SPLIT: begin
        r.low = lo + 8'h01;
        r.ovf = (lo == 8'hff);
      end
    endcase
    return r;
  endfunction : dlt_step

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PIN_N-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [5:0] presc_cnt_reg;
  logic [2:0] ext_cnt_reg;
  logic run_a_reg, run_b_reg, flag_a_reg, flag_b_reg;
  logic flag_a_next, flag_b_next;
  logic [7:0] mode_reg, clk_ctl_reg;
  logic [1:0] ext_cfg_reg, int_en_reg;
  logic [7:0] a_low_reg, a_high_reg, b_low_reg, b_high_reg;
  logic irq_a_reg, irq_b_reg, b_ovf_reg;
  dlt_apb_rsp_s rsp_reg;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup, wr_go;
  logic [7:0] wdat;
  logic [31:0] rd_data;
  logic addr_ok;
  assign setup = apb_req.psel & ~apb_req.penable;
  // writes land only on the completing access edge
  assign wr_go = apb_req.psel & apb_req.penable & apb_req.pwrite & rsp_reg.pready;
  assign wdat = apb_req.pwdata[7:0];

  // read mux and address check
  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (apb_req.paddr)
      ADDR_CTRL: rd_data[7:0] = {flag_b_reg, run_b_reg, flag_a_reg, run_a_reg, 4'h0};
      ADDR_MODE: rd_data[7:0] = mode_reg;
      ADDR_CLK: rd_data[7:0] = clk_ctl_reg;
      ADDR_A_LOW: rd_data[7:0] = a_low_reg;
      ADDR_A_HIGH: rd_data[7:0] = a_high_reg;
      ADDR_B_LOW: rd_data[7:0] = b_low_reg;
      ADDR_B_HIGH: rd_data[7:0] = b_high_reg;
      ADDR_EXTCFG: rd_data[1:0] = ext_cfg_reg;
      ADDR_INTEN: rd_data[1:0] = int_en_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  // no wait state: answer is prepared at the setup edge
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.pready <= setup;
      rsp_reg.pslverr <= setup & ~addr_ok;
      if (setup) begin
        rsp_reg.prdata <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // first stage feeds only the second; edges compare stages two and three
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= {ext_clk_pin, gate_input_b, gate_input_a, timer_b_event_pin,
                    timer_a_event_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic fall_a, fall_b, ext_rise;
  // a level held two clocks is always seen, so quarter-rate events count
  assign fall_a = sync3_reg[PIN_EV_A] & ~sync2_reg[PIN_EV_A];
  assign fall_b = sync3_reg[PIN_EV_B] & ~sync2_reg[PIN_EV_B];
  assign ext_rise = ~sync3_reg[PIN_EXT] & sync2_reg[PIN_EXT];

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [1:0] presc_sel;
  logic [5:0] presc_div;
  logic int_tick, ext_tick, presc_tick;
  assign presc_sel = clk_ctl_reg[CLK_PRESC_LSB +: 2];
  always_comb begin
    unique case (presc_sel)
      PRESC_DIV4: presc_div = DIV_4;
      PRESC_DIV48: presc_div = DIV_48;
      default: presc_div = DIV_12;
    endcase
  end
  // >= keeps the divider sane when the selection shrinks mid-count
  assign int_tick = (presc_cnt_reg >= presc_div - 6'h01);
  assign ext_tick = ext_rise & (ext_cnt_reg == EXT_DIV_LAST);
  assign presc_tick = (presc_sel == PRESC_EXT8) ? ext_tick : int_tick;

  always_ff @(posedge clk) begin
    if (reset || int_tick) begin
      presc_cnt_reg <= '0;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 6'h01;
    end
  end

  // external clock divided by eight, already on clk
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_cnt_reg <= '0;
    end else if (ext_rise) begin
      ext_cnt_reg <= ext_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // advance conditions
  // ----------------------------------------------------------------
  logic [1:0] mode_a, mode_b;
  logic split, gate_ok_a, gate_ok_b, tick_a, tick_ah, tick_b;
  logic en_a, en_b, adv_a, adv_ah, adv_b;
  assign mode_a = mode_reg[MODE_A_LSB +: 2];
  assign mode_b = mode_reg[MODE_B_LSB +: 2];
  assign split = (mode_a == MODE_SPLIT);
  // gate polarity: 1 means active high
  assign gate_ok_a = ~mode_reg[MODE_A_GATE]
                   | (sync2_reg[PIN_GATE_A] == ext_cfg_reg[EXTCFG_A_POL]);
  assign gate_ok_b = ~mode_reg[MODE_B_GATE]
                   | (sync2_reg[PIN_GATE_B] == ext_cfg_reg[EXTCFG_B_POL]);
  assign tick_a = mode_reg[MODE_A_CT] ? fall_a
                : (clk_ctl_reg[CLK_A_SYS] | presc_tick);
  // split high byte never counts pins
  assign tick_ah = clk_ctl_reg[CLK_A_SYS] | presc_tick;
  assign tick_b = (mode_reg[MODE_B_CT] & ~split) ? fall_b
                : (clk_ctl_reg[CLK_B_SYS] | presc_tick);
  assign en_a = run_a_reg & gate_ok_a;
  // in split, timer b runs purely by its mode
  assign en_b = split ? 1'b1 : (run_b_reg & gate_ok_b);
  assign adv_a = en_a & tick_a;
  assign adv_ah = split & run_b_reg & tick_ah;
  assign adv_b = (mode_b != MODE_SPLIT) & en_b & tick_b;

  dlt_step_s step_a, step_b;
  assign step_a = dlt_step(mode_a, a_low_reg, a_high_reg);
  assign step_b = dlt_step(mode_b, b_low_reg, b_high_reg);

  logic ovf_a_evt, ovf_ah_evt, ovf_b_evt, set_a, set_b;
  assign ovf_a_evt = adv_a & step_a.ovf;
  assign ovf_ah_evt = adv_ah & (a_high_reg == 8'hff);
  assign ovf_b_evt = adv_b & step_b.ovf;
  assign set_a = ovf_a_evt;
  assign set_b = split ? ovf_ah_evt : ovf_b_evt;

  // ----------------------------------------------------------------
  // count registers; a software write beats a count in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      a_low_reg <= RST_BYTE;
      a_high_reg <= RST_BYTE;
    end else begin
      if (wr_go && apb_req.paddr == ADDR_A_LOW) begin
        a_low_reg <= wdat;
      end else if (adv_a) begin
        a_low_reg <= step_a.low;
      end
      if (wr_go && apb_req.paddr == ADDR_A_HIGH) begin
        a_high_reg <= wdat;
      end else if (split) begin
        if (adv_ah) begin
          a_high_reg <= a_high_reg + 8'h01;
        end
      end else if (adv_a) begin
        a_high_reg <= step_a.high;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      b_low_reg <= RST_BYTE;
      b_high_reg <= RST_BYTE;
    end else begin
      if (wr_go && apb_req.paddr == ADDR_B_LOW) begin
        b_low_reg <= wdat;
      end else if (adv_b) begin
        b_low_reg <= step_b.low;
      end
      if (wr_go && apb_req.paddr == ADDR_B_HIGH) begin
        b_high_reg <= wdat;
      end else if (adv_b) begin
        b_high_reg <= step_b.high;
      end
    end
  end

  // ----------------------------------------------------------------
  // control, mode and configuration registers
  // ----------------------------------------------------------------
  // run bits only gate counting; they never touch the count
  always_ff @(posedge clk) begin
    if (reset) begin
      run_a_reg <= 1'b0;
      run_b_reg <= 1'b0;
    end else if (wr_go && apb_req.paddr == ADDR_CTRL) begin
      run_a_reg <= wdat[CTRL_A_RUN];
      run_b_reg <= wdat[CTRL_B_RUN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg <= RST_BYTE;
      clk_ctl_reg <= RST_BYTE;
      ext_cfg_reg <= '0;
      int_en_reg <= '0;
    end else if (wr_go) begin
      if (apb_req.paddr == ADDR_MODE) mode_reg <= wdat;
      if (apb_req.paddr == ADDR_CLK) clk_ctl_reg <= {4'h0, wdat[3:0]};
      if (apb_req.paddr == ADDR_EXTCFG) ext_cfg_reg <= wdat[1:0];
      if (apb_req.paddr == ADDR_INTEN) int_en_reg <= wdat[1:0];
    end
  end

  // ----------------------------------------------------------------
  // overflow flags: a hardware set wins over any clear
  // ----------------------------------------------------------------
  logic wr_ctrl;
  assign wr_ctrl = wr_go & (apb_req.paddr == ADDR_CTRL);
  always_comb begin
    flag_a_next = (wr_ctrl ? wdat[CTRL_A_FLAG] : flag_a_reg) & ~isr_ack_a;
    flag_b_next = (wr_ctrl ? wdat[CTRL_B_FLAG] : flag_b_reg) & ~isr_ack_b;
    flag_a_next = flag_a_next | set_a;
    flag_b_next = flag_b_next | set_b;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else begin
      flag_a_reg <= flag_a_next;
      flag_b_reg <= flag_b_next;
    end
  end

  // interrupts follow flags one clock later, masked by enables
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
      b_ovf_reg <= 1'b0;
    end else begin
      irq_a_reg <= flag_a_reg & int_en_reg[INTEN_A];
      irq_b_reg <= flag_b_reg & int_en_reg[INTEN_B];
      b_ovf_reg <= ovf_b_evt;
    end
  end

  assign apb_rsp = rsp_reg;
  assign irq_timer_a = irq_a_reg;
  assign irq_timer_b = irq_b_reg;
  assign timer_b_overflow_pulse = b_ovf_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [15:0] cnt_a16, cnt_b16;
  assign cnt_a16 = {a_high_reg, a_low_reg};
  assign cnt_b16 = {b_high_reg, b_low_reg};

  property p_fall_counts;
    (mode_a == MODE_16) && en_a && mode_reg[MODE_A_CT] && fall_a && !wr_go
      |=> cnt_a16 == $past(cnt_a16) + 16'h0001;
  endproperty
  a_fall_counts: assert property (p_fall_counts) else $error("edge not counted");

  property p_hold;
    !en_a && !split && !wr_go |=> $stable(cnt_a16);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");

  property p_wrap13;
    (mode_a == MODE_13) && adv_a && ({a_high_reg, a_low_reg[4:0]} == 13'h1fff) && !wr_go
      |=> flag_a_reg && a_high_reg == 8'h00 && a_low_reg[4:0] == 5'h00;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong");

  // watched on timer b, whose reload path the baud use exercises most
  property p_reload;
    (mode_b == MODE_RELOAD) && !split && adv_b && b_low_reg == 8'hff && !wr_go
      |=> b_low_reg == $past(b_high_reg) && $stable(b_high_reg) && flag_b_reg;
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong");

  property p_split_high;
    split && run_b_reg && tick_ah && a_high_reg == 8'hff && !wr_go
      |=> flag_b_reg && a_high_reg == 8'h00;
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high overflow");

  property p_b_noflag;
    split && !ovf_ah_evt && !flag_b_reg && !wr_go |=> !flag_b_reg;
  endproperty
  a_b_noflag: assert property (p_b_noflag) else $error("timer b flagged in split");

  property p_b_stop;
    (mode_b == MODE_SPLIT) && !wr_go |=> $stable(cnt_b16) ##1 !timer_b_overflow_pulse;
  endproperty
  a_b_stop: assert property (p_b_stop) else $error("timer b ran in mode 3");

  property p_b_baud;
    ovf_b_evt |=> timer_b_overflow_pulse ##1 (!timer_b_overflow_pulse || $past(ovf_b_evt));
  endproperty
  a_b_baud: assert property (p_b_baud) else $error("overflow pulse missing");

  sequence s_ovf_enabled;
    ovf_a_evt && int_en_reg[INTEN_A] && !isr_ack_a && !wr_go;
  endsequence
  sequence s_kept;
    !isr_ack_a && !wr_go;
  endsequence
  property p_irq;
    s_ovf_enabled ##1 s_kept |=> irq_timer_a;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled overflow gave no irq");

  property p_irq_masked;
    !int_en_reg[INTEN_A] && !wr_go |=> !irq_timer_a;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq fired");

  property p_ack_clear;
    isr_ack_a && !set_a |=> !flag_a_reg;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("vector did not clear");

endmodule : dlt_timers

// *** bench/dlt_pin_model.sv ***
`timescale 1ns/1ps
module dlt_pin_model (
  // system clock
  input wire logic clk,
  // pins toward the timers
  output logic ev_a,
  output logic ev_b,
  output logic gate_a,
  output logic gate_b,
  output logic ext_clk
);
  logic ext_on;
  logic ext_half;

  // idle levels; event pins rest high so every drive starts with a fall
  initial begin
    ev_a = 1'b1;
    ev_b = 1'b1;
    gate_a = 1'b0;
    gate_b = 1'b0;
    ext_clk = 1'b0;
    ext_on = 1'b0;
    ext_half = 1'b0;
  end

  // external clock of four system cycles, frozen while disabled
  // each level stands two clocks so the synchroniser never misses one
  always @(posedge clk) begin
    if (ext_on) begin
      ext_half <= ~ext_half;
      if (ext_half) begin
        ext_clk <= ~ext_clk;
      end
    end
  end

  // gate levels and external clock enable, changed just after an edge
  task automatic set_pins(input logic ga, input logic gb, input logic eo);
    gate_a <= ga;
    gate_b <= gb;
    ext_on <= eo;
  endtask : set_pins

  // n falls, each level held two clocks: the fastest legal event rate
  task automatic fall(input logic sel_b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (sel_b) ev_b <= 1'b0;
      else ev_a <= 1'b0;
      repeat (2) @(posedge clk);
      if (sel_b) ev_b <= 1'b1;
      else ev_a <= 1'b1;
      @(posedge clk);
    end
  endtask : fall
endmodule : dlt_pin_model

// *** bench/dual_legacy_counter_timers_tb_top.sv ***
`timescale 1ns/1ps
module dual_legacy_counter_timers_tb_top import dlt_pkg::*;;
  // ----------------------------------------------------------------
  // clock, reset and hookup
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset;
  dlt_apb_req_s apb_req;
  dlt_apb_rsp_s apb_rsp;
  logic isr_ack_a;
  logic isr_ack_b;
  wire logic ev_a, ev_b, gate_a, gate_b, ext_clk;
  wire logic [2:0] outs;
  int miscompares;
  int checks_done;
  int n;
  logic [31:0] rd;
  logic err;
  logic [7:0] clk_sel [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
  // ext clock runs at a quarter rate, so its /8 is 32 system ticks
  int ticks [5] = '{DIV_12, DIV_4, DIV_48, 8 * 4, 1};

  // 40 ns system clock
  always #20 clk = ~clk;

  dlt_pin_model i_pins (
    .clk(clk), .ev_a(ev_a), .ev_b(ev_b), .gate_a(gate_a), .gate_b(gate_b),
    .ext_clk(ext_clk)
  );

  dlt_timers i_dut (
    .clk(clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .timer_a_event_pin(ev_a), .timer_b_event_pin(ev_b),
    .gate_input_a(gate_a), .gate_input_b(gate_b), .ext_clk_pin(ext_clk),
    .isr_ack_a(isr_ack_a), .isr_ack_b(isr_ack_b),
    .irq_timer_a(outs[0]), .irq_timer_b(outs[1]),
    .timer_b_overflow_pulse(outs[2])
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr_en, input logic [7:0] addr,
                     input logic [7:0] data);
    int k;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, wr_en, addr, {24'h0, data}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 16);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    if (apb_rsp.pready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    apb(1'b1, addr, data);
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    apb(1'b0, addr, 8'h00);
    check($sformatf("reg %h", addr), rd, {24'h0, exp});
  endtask : rd_chk

  // bounded wait for one of the design outputs to be seen high
  task automatic wait_hi(input int idx, output int k);
    k = 0;
    while (outs[idx] !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (outs[idx] !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_hi

  task automatic ack(input logic sel_b);
    @(posedge clk);
    if (sel_b) isr_ack_b <= 1'b1;
    else isr_ack_a <= 1'b1;
    @(posedge clk);
    isr_ack_a <= 1'b0;
    isr_ack_b <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : ack

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    apb_req = '0;
    reset = 1'b1;
    isr_ack_a = 1'b0;
    isr_ack_b = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // reset values, byte access to the counts, an unmapped slot
    for (int i = 0; i < 9; i++) rd_chk(8'(4 * i), 8'h00);
    for (int i = 0; i < 4; i++) wr(8'(ADDR_A_LOW + 4 * i), 8'(8'h5a + i));
    for (int i = 0; i < 4; i++) rd_chk(8'(ADDR_A_LOW + 4 * i), 8'(8'h5a + i));
    apb(1'b1, 8'h24, 8'hff);
    apb(1'b0, 8'h24, 8'h00);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    // 16-bit event count from a preload, wrapping into the flag
    wr(ADDR_INTEN, 8'h01);
    wr(ADDR_A_LOW, 8'hfd);
    wr(ADDR_A_HIGH, 8'hff);
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_CTRL, 8'h10);
    i_pins.fall(1'b0, 3);
    repeat (4) @(posedge clk);
    check("irq a", {31'h0, outs[0]}, 32'h1);
    rd_chk(ADDR_A_LOW, 8'h00);
    rd_chk(ADDR_A_HIGH, 8'h00);
    rd_chk(ADDR_CTRL, 8'h30);
    ack(1'b0);
    check("irq a acked", {31'h0, outs[0]}, 32'h0);
    rd_chk(ADDR_CTRL, 8'h10);
    // 13-bit wrap with the interrupt masked
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_INTEN, 8'h00);
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_A_LOW, 8'h1e);
    wr(ADDR_A_HIGH, 8'hff);
    wr(ADDR_CTRL, 8'h10);
    i_pins.fall(1'b0, 2);
    repeat (4) @(posedge clk);
    check("irq a masked", {31'h0, outs[0]}, 32'h0);
    apb(1'b0, ADDR_A_LOW, 8'h00);
    check("low five bits", rd & 32'h1f, 32'h0);
    rd_chk(ADDR_A_HIGH, 8'h00);
    rd_chk(ADDR_CTRL, 8'h30);
    wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_CTRL, 8'h00);
    // timer b gated by its own input and polarity
    wr(ADDR_EXTCFG, 8'h02);
    wr(ADDR_MODE, 8'hd0);
    wr(ADDR_B_LOW, 8'h00);
    wr(ADDR_B_HIGH, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    i_pins.fall(1'b1, 2);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_B_LOW, 8'h00);
    i_pins.set_pins(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    i_pins.fall(1'b1, 3);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_B_LOW, 8'h03);
    wr(ADDR_EXTCFG, 8'h00);
    i_pins.fall(1'b1, 2);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_B_LOW, 8'h03);
    rd_chk(ADDR_A_LOW, 8'h00);
    // reload from fe: one overflow every two ticks of each source
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_B_HIGH, 8'hfe);
    wr(ADDR_B_LOW, 8'hfe);
    i_pins.set_pins(1'b0, 1'b1, 1'b1);
    wr(ADDR_CTRL, 8'h40);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CLK, clk_sel[i]);
      wait_hi(2, n);
      @(posedge clk);
      wait_hi(2, n);
      @(posedge clk);
      wait_hi(2, n);
      check("overflow period", n + 1, 2 * ticks[i]);
    end
    rd_chk(ADDR_B_HIGH, 8'hfe);
    // split timer a: b runs flagless, then mode 3 stops it
    wr(ADDR_CTRL, 8'h00);
    // timer b may overflow on the stopping write itself, and a set beats the clear
    wr(ADDR_CTRL, 8'h00);
    i_pins.set_pins(1'b0, 1'b1, 1'b0);
    wr(ADDR_INTEN, 8'h02);
    wr(ADDR_B_HIGH, 8'hff);
    wr(ADDR_B_LOW, 8'hf0);
    wr(ADDR_CLK, 8'h08);
    wr(ADDR_MODE, 8'h13);
    wait_hi(2, n);
    repeat (4) @(posedge clk);
    check("irq b in split", {31'h0, outs[1]}, 32'h0);
    rd_chk(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h33);
    wr(ADDR_B_LOW, 8'h77);
    repeat (8) @(posedge clk);
    rd_chk(ADDR_B_LOW, 8'h77);
    // high byte of a driven by b's run, flagging timer b
    wr(ADDR_CLK, 8'h04);
    wr(ADDR_A_HIGH, 8'hf0);
    wr(ADDR_CTRL, 8'h40);
    wait_hi(1, n);
    rd_chk(ADDR_CTRL, 8'hc0);
    ack(1'b1);
    check("irq b acked", {31'h0, outs[1]}, 32'h0);
    // low byte of a counts events under a's own controls and gate
    wr(ADDR_MODE, 8'h3f);
    wr(ADDR_EXTCFG, 8'h01);
    wr(ADDR_A_LOW, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    i_pins.fall(1'b0, 2);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_A_LOW, 8'h00);
    i_pins.set_pins(1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    i_pins.fall(1'b0, 3);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_A_LOW, 8'h03);
    end_sim();
  end
endmodule : dual_legacy_counter_timers_tb_top
